// ### sem_pkg.sv
// Constants, register map and field layout of the event-mask and underrun-fill unit.
// Assumes an APB slave with 32-bit data and one aligned word per register.
// Overview of operation
// - Frame error raises an event when frame_error_event_en (bit 12) is set.
// - Busy activity raises an event when activity_event_en (bit 11) is set.
// - Transmit underrun raises an event when underrun_event_en (bit 8) is set.
// - Empty transmit path raises events when shift_empty_event_en (bit 7) is set.
// - Receive overflow raises an event when overflow_event_en (bit 6) is set.
// - Empty receive buffer raises an event when rx_empty_event_en (bit 5) is set.
// - Empty transmit buffer raises an event when tx_empty_event_en (bit 3) is set.
// - Full transmit buffer raises an event when tx_full_event_en (bit 1) is set.
// - Full receive buffer raises an event when rx_full_event_en (bit 0) is set.
// - Receive watermark fires when enabled and rx threshold is at most rx count.
// - Transmit watermark fires when enabled and tx threshold equals tx count.
// - No watermark match ever when a threshold exceeds the FIFO depth.
// - Threshold bit 2 exists from depth 8, bit 3 from 16, bit 4 at 32.
// - Underrun fill value replaces buffer data on underrun when fill is enabled.
// - Lengths 9-16 use the low fill half-word; 2-8 use its low byte.
// - Lengths 25-32 use the whole high half-word; 17-24 its low byte.
// - Serial clock is bus clock divided by twice the sum of divisor and one.
// - Unimplemented mask register bits read as zero.
// - Six-bit rx and tx element counts feed the watermark comparisons.
package sem_pkg;
   localparam logic [7:0] SEM_OFF_EVMASK = 8'h00;
   localparam logic [7:0] SEM_OFF_WMMASK = 8'h04;
   localparam logic [7:0] SEM_OFF_FILLLO = 8'h08;
   localparam logic [7:0] SEM_OFF_FILLHI = 8'h0C;
   localparam logic [7:0] SEM_OFF_BAUD = 8'h10;
   localparam logic [7:0] SEM_OFF_STATUS = 8'h14;

   localparam int SEM_B_RXFULL = 0;
   localparam int SEM_B_TXFULL = 1;
   localparam int SEM_B_TXEMPTY = 3;
   localparam int SEM_B_RXEMPTY = 5;
   localparam int SEM_B_OVF = 6;
   localparam int SEM_B_SHEMPTY = 7;
   localparam int SEM_B_UNDERRUN = 8;
   localparam int SEM_B_ACT = 11;
   localparam int SEM_B_FRAME_ERROR_FLAG = 12;
   localparam logic [15:0] SEM_EVMASK_IMPL = 16'h19EB;

   localparam int SEM_THR_W = 6;
   localparam int SEM_RXWEN_BIT = 15;
   localparam int SEM_RXTHR_LSB = 8;
   localparam int SEM_TXWEN_BIT = 7;
   localparam int SEM_TXTHR_LSB = 0;
   localparam logic [5:0] SEM_THR_BASE = 6'h23;
   localparam logic [5:0] SEM_THR_B2 = 6'h04;
   localparam logic [5:0] SEM_THR_B3 = 6'h08;
   localparam logic [5:0] SEM_THR_B4 = 6'h10;
   localparam int SEM_DEPTH_B2 = 8;
   localparam int SEM_DEPTH_B3 = 16;
   localparam int SEM_DEPTH_B4 = 32;

   localparam int SEM_WL_W = 5;
   localparam logic [4:0] SEM_WL_8 = 5'h07;
   localparam logic [4:0] SEM_WL_16 = 5'h0F;
   localparam logic [4:0] SEM_WL_24 = 5'h17;

   localparam int SEM_BAUD_W = 13;
   localparam logic [15:0] SEM_RST16 = 16'h0000;

   typedef enum logic {SEM_IDLE, SEM_ACK} sem_bus_t;

   function automatic logic [5:0] sem_thr_keep(input int depth);
      logic [5:0] k;
      k = SEM_THR_BASE;
      if (depth >= SEM_DEPTH_B2) k = k | SEM_THR_B2;
      if (depth >= SEM_DEPTH_B3) k = k | SEM_THR_B3;
      if (depth >= SEM_DEPTH_B4) k = k | SEM_THR_B4;
      return k;
   endfunction
endpackage

// ### sem_wm_match.sv
// Watermark comparator for one FIFO direction.
// Assumes the threshold is already stripped of bits the depth does not implement.
`timescale 1ns/1ns
module sem_wm_match
   import sem_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter bit EXACT = 1'b0
) (
   input wire logic [5:0] thresh,
   input wire logic [5:0] count,
   output logic match
);
   localparam logic [6:0] DEPTH_V = 7'(DEPTH);
   logic inRange;

   // Out-of-range thresholds are dead rather than aliased onto a smaller value
   assign inRange = {1'b0, thresh} <= DEPTH_V;
   assign match = inRange && (EXACT ? (thresh == count) : (thresh <= count));

   always_comb begin
      assert (inRange || !match) else $error("watermark matched beyond depth");
   end
endmodule

// ### sem_event_unit.sv
// Event masking, watermark interrupt, underrun fill word and baud divider.
// Assumes status flags and element counts arrive synchronous to sys_clk from the SPI core.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module sem_event_unit
   import sem_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frameErrorFlag,
   input wire logic activityFlag,
   input wire logic underrunFlag,
   input wire logic shiftEmptyFlag,
   input wire logic overflowFlag,
   input wire logic rxEmptyFlag,
   input wire logic txEmptyFlag,
   input wire logic txFullFlag,
   input wire logic rxFullFlag,
   input wire logic [5:0] rxElementCount,
   input wire logic [5:0] txElementCount,
   input wire logic underrunFillEn,
   input wire logic [4:0] wordLengthSel,
   input wire logic peripheralEnable,
   input wire logic [31:0] bufTxWord,
   output logic [31:0] txWord,
   output logic serialClk,
   output logic irqReq
);
   localparam logic [5:0] THR_KEEP = sem_thr_keep(FIFO_DEPTH);

   typedef struct packed {
      sem_bus_t busState;
      logic [31:0] rdData;
      logic slvErr;
      logic [15:0] evMask;
      logic [15:0] wmMask;
      logic [15:0] fillLo;
      logic [15:0] fillHi;
      logic [12:0] baud;
      logic [12:0] baudCnt;
      logic sclk;
      logic irq;
      logic [31:0] txWord;
   } sem_state_t;

   sem_state_t st_reg;
   sem_state_t st_next;
   logic [15:0] flagVec;
   logic [5:0] rxThr;
   logic [5:0] txThr;
   logic rxWEn;
   logic txWEn;
   logic rxWmHit;
   logic txWmHit;
   logic evHit;
   logic addrHit;
   logic [31:0] rdWord;
   logic [31:0] fillWord;
   logic [15:0] wrMaskHi;

   assign flagVec = {3'h0, frameErrorFlag, activityFlag, 2'h0, underrunFlag,
                     shiftEmptyFlag, overflowFlag, rxEmptyFlag, 1'b0, txEmptyFlag,
                     1'b0, txFullFlag, rxFullFlag};
   assign rxThr = st_reg.wmMask[SEM_RXTHR_LSB +: SEM_THR_W];
   assign txThr = st_reg.wmMask[SEM_TXTHR_LSB +: SEM_THR_W];
   assign rxWEn = st_reg.wmMask[SEM_RXWEN_BIT];
   assign txWEn = st_reg.wmMask[SEM_TXWEN_BIT];

   sem_wm_match #(
      .DEPTH(FIFO_DEPTH),
      .EXACT(1'b0)
   ) rxMatch (
      .thresh(rxThr),
      .count(rxElementCount),
      .match(rxWmHit)
   );

   sem_wm_match #(
      .DEPTH(FIFO_DEPTH),
      .EXACT(1'b1)
   ) txMatch (
      .thresh(txThr),
      .count(txElementCount),
      .match(txWmHit)
   );

   // Each flag counts only while its enable bit is set
   assign evHit = |(st_reg.evMask & flagVec);

   assign addrHit = (paddr == SEM_OFF_EVMASK) || (paddr == SEM_OFF_WMMASK) ||
                    (paddr == SEM_OFF_FILLLO) || (paddr == SEM_OFF_FILLHI) ||
                    (paddr == SEM_OFF_BAUD) || (paddr == SEM_OFF_STATUS);

   // Threshold bits absent at this depth and both gaps are never stored
   assign wrMaskHi = {2'b10, THR_KEEP, 2'b10, THR_KEEP};

   always_comb begin
      rdWord = 32'h0000_0000;
      case (paddr)
         SEM_OFF_EVMASK: rdWord = {16'h0000, st_reg.evMask};
         SEM_OFF_WMMASK: rdWord = {16'h0000, st_reg.wmMask};
         SEM_OFF_FILLLO: rdWord = {16'h0000, st_reg.fillLo};
         SEM_OFF_FILLHI: rdWord = {16'h0000, st_reg.fillHi};
         SEM_OFF_BAUD: rdWord = {19'h00000, st_reg.baud};
         // Counts and flags leave bits 31:30 and 23:22 zero; match bits are visible only as irqReq
         SEM_OFF_STATUS: rdWord = {2'h0, rxElementCount, 2'h0, txElementCount,
                                   flagVec};
         default: rdWord = 32'h0000_0000;
      endcase
   end

   always_comb begin
      fillWord = {st_reg.fillHi, st_reg.fillLo};
      if (wordLengthSel <= SEM_WL_8) begin
         fillWord = {24'h000000, st_reg.fillLo[7:0]};
      end else if (wordLengthSel <= SEM_WL_16) begin
         fillWord = {16'h0000, st_reg.fillLo};
      end else if (wordLengthSel <= SEM_WL_24) begin
         fillWord = {8'h00, st_reg.fillHi[7:0], st_reg.fillLo};
      end
   end

   always_comb begin
      st_next = st_reg;
      case (st_reg.busState)
         SEM_IDLE: begin
            // Read data is sampled a cycle early so prdata comes from a flop
            if (psel && penable) begin
               st_next.rdData = rdWord;
               st_next.slvErr = !addrHit;
               st_next.busState = SEM_ACK;
            end
         end
         SEM_ACK: begin
            st_next.busState = SEM_IDLE;
            if (psel && penable && pwrite) begin
               case (paddr)
                  SEM_OFF_EVMASK: st_next.evMask = pwdata[15:0] & SEM_EVMASK_IMPL;
                  SEM_OFF_WMMASK: st_next.wmMask = pwdata[15:0] & wrMaskHi;
                  SEM_OFF_FILLLO: st_next.fillLo = pwdata[15:0];
                  SEM_OFF_FILLHI: st_next.fillHi = pwdata[15:0];
                  // Divisor is taken as is; a change while enabled glitches the clock
                  SEM_OFF_BAUD: st_next.baud = pwdata[SEM_BAUD_W-1:0];
                  default: st_next.baud = st_reg.baud;
               endcase
            end
         end
         default: st_next.busState = SEM_IDLE;
      endcase

      if (!peripheralEnable) begin
         st_next.baudCnt = 13'h0000;
         st_next.sclk = 1'b0;
      end else if (st_reg.baudCnt >= st_reg.baud) begin
         st_next.baudCnt = 13'h0000;
         st_next.sclk = !st_reg.sclk;
      end else begin
         st_next.baudCnt = st_reg.baudCnt + 13'h0001;
      end

      st_next.irq = evHit || (rxWEn && rxWmHit) || (txWEn && txWmHit);
      st_next.txWord = (underrunFlag && underrunFillEn) ? fillWord : bufTxWord;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pready = (st_reg.busState == SEM_ACK) && psel && penable;
   assign pslverr = pready && st_reg.slvErr;
   assign prdata = st_reg.rdData;
   assign txWord = st_reg.txWord;
   assign serialClk = st_reg.sclk;
   assign irqReq = st_reg.irq;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   frame_err_irq_a: assert property (frameErrorFlag && st_reg.evMask[SEM_B_FRAME_ERROR_FLAG] |=> irqReq) else $error("frame error event lost");
   busy_irq_a: assert property (activityFlag && st_reg.evMask[SEM_B_ACT] |=> irqReq) else $error("activity event lost");
   underrun_irq_a: assert property (underrunFlag && st_reg.evMask[SEM_B_UNDERRUN] |=> irqReq) else $error("underrun event lost");
   shift_empty_irq_a: assert property (shiftEmptyFlag && st_reg.evMask[SEM_B_SHEMPTY] |=> irqReq) else $error("shift empty event lost");
   overflow_irq_a: assert property (overflowFlag && st_reg.evMask[SEM_B_OVF] |=> irqReq) else $error("overflow event lost");
   rx_empty_irq_a: assert property (rxEmptyFlag && st_reg.evMask[SEM_B_RXEMPTY] |=> irqReq) else $error("rx empty event lost");
   tx_empty_irq_a: assert property (txEmptyFlag && st_reg.evMask[SEM_B_TXEMPTY] |=> irqReq) else $error("tx empty event lost");
   tx_full_irq_a: assert property (txFullFlag && st_reg.evMask[SEM_B_TXFULL] |=> irqReq) else $error("tx full event lost");
   rx_full_irq_a: assert property (rxFullFlag && st_reg.evMask[SEM_B_RXFULL] |=> irqReq) else $error("rx full event lost");
   rx_wm_irq_a: assert property (rxWEn && rxThr <= rxElementCount && rxThr <= 6'(FIFO_DEPTH) |=> irqReq) else $error("rx watermark missed");
   tx_wm_irq_a: assert property (txWEn && txThr == txElementCount && txThr <= 6'(FIFO_DEPTH) |=> irqReq) else $error("tx watermark missed");
   wm_range_a: assert property (txThr > 6'(FIFO_DEPTH) |-> !txWmHit) else $error("tx match beyond depth");
   thr_bits_a: assert property ((st_reg.wmMask & ~wrMaskHi) == 16'h0000) else $error("absent threshold bit stored");
   irq_quiet_a: assert property (!evHit && !(rxWEn && rxWmHit) && !(txWEn && txWmHit) |=> !irqReq) else $error("spurious interrupt");
   fill_sub_a: assert property (underrunFlag && underrunFillEn && wordLengthSel > SEM_WL_24 |=> txWord == {$past(st_reg.fillHi), $past(st_reg.fillLo)}) else $error("fill word wrong");
   fill_byte_a: assert property (underrunFlag && underrunFillEn && wordLengthSel <= SEM_WL_8 |=> txWord == {24'h000000, $past(st_reg.fillLo[7:0])}) else $error("short fill word wrong");
   no_fill_a: assert property (!underrunFlag |=> txWord == $past(bufTxWord)) else $error("buffer data not passed");
   baud_toggle_a: assert property (peripheralEnable && st_reg.baudCnt >= st_reg.baud && $past(peripheralEnable) |=> !peripheralEnable || serialClk != $past(serialClk)) else $error("serial clock missed toggle");
   baud_hold_a: assert property (peripheralEnable && st_reg.baudCnt < st_reg.baud |=> !peripheralEnable || $stable(serialClk)) else $error("serial clock toggled early");
   rsvd_zero_a: assert property (pready && paddr == SEM_OFF_EVMASK |-> (prdata & ~{16'h0000, SEM_EVMASK_IMPL}) == 32'h0000_0000) else $error("reserved bit read as one");

   irq_seen_c: cover property (!irqReq ##1 irqReq);
   fill_used_c: cover property (underrunFlag && underrunFillEn);
   wm_tx_c: cover property (txWEn && txWmHit);
   apb_write_c: cover property (pready && pwrite && paddr == SEM_OFF_WMMASK);
endmodule

// ### sem_spi_peer.sv
// Far-side SPI peer: watches the serial clock and the word offered for shifting.
// Assumes serialClk and txWord are registered on sys_clk by the unit.
`timescale 1ns/1ns
module sem_spi_peer (
   input wire logic sys_clk,
   input wire logic serialClk,
   input wire logic [31:0] txWord,
   output logic [15:0] periodCnt,
   output logic [31:0] lastWord
);
   logic [15:0] runCnt = 16'h0000;
   logic prevClk = 1'b0;
   initial periodCnt = 16'h0000;
   initial lastWord = 32'h00000000;
   // Period is counted between rising edges, so duty cycle errors do not show here
   always @(posedge sys_clk) begin
      prevClk <= serialClk;
      if (serialClk && !prevClk) begin
         periodCnt <= runCnt + 16'h0001;
         runCnt <= 16'h0000;
         lastWord <= txWord;
      end else begin
         runCnt <= runCnt + 16'h0001;
      end
   end
endmodule

// ### spi_event_mask_underrun_bench.sv
// Self-checking bench for the event-mask and underrun-fill unit.
// Assumes APB with one wait state and registered outputs one cycle after their cause.
`timescale 1ns/1ns
module spi_event_mask_underrun_bench;
   import sem_pkg::*;
   localparam int DEPTH = 16;
   logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, bufTxWord = 32'h00000000;
   logic [15:0] flagVec = 16'h0000;
   logic [5:0] rxCnt = 6'h00, txCnt = 6'h00;
   logic fillEn = 1'b0, perEn = 1'b0;
   logic [4:0] wlSel = 5'h07;
   logic [31:0] prdata, txWord, lastWord;
   logic pready, pslverr, serialClk, irqReq;
   logic [15:0] periodCnt;
   int fails = 0, n_tests = 0, cyc = 0, seed = 32'h0C1E5BB0;
   sem_event_unit #(.FIFO_DEPTH(DEPTH)) uut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .frameErrorFlag(flagVec[12]),
      .activityFlag(flagVec[11]), .underrunFlag(flagVec[8]), .shiftEmptyFlag(flagVec[7]),
      .overflowFlag(flagVec[6]), .rxEmptyFlag(flagVec[5]), .txEmptyFlag(flagVec[3]),
      .txFullFlag(flagVec[1]), .rxFullFlag(flagVec[0]), .rxElementCount(rxCnt),
      .txElementCount(txCnt), .underrunFillEn(fillEn), .wordLengthSel(wlSel),
      .peripheralEnable(perEn), .bufTxWord(bufTxWord), .txWord(txWord),
      .serialClk(serialClk), .irqReq(irqReq));
   sem_spi_peer peer (.sys_clk(sys_clk), .serialClk(serialClk), .txWord(txWord),
      .periodCnt(periodCnt), .lastWord(lastWord));
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      // Whole run needs well under 10000 cycles
      if (cyc > 20000) begin
         fails++;
         results();
      end
   end
   task automatic results();
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer; returns one edge after release so strobes never toggle twice
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   function automatic logic [31:0] expFill(input logic [31:0] lo, input logic [31:0] hi,
      input logic [4:0] wl, input logic [31:0] bw, input logic uf, input logic en);
      if (!(uf && en)) return bw;
      if (wl <= 5'h07) return {24'h000000, lo[7:0]};
      if (wl <= 5'h0F) return {16'h0000, lo[15:0]};
      if (wl <= 5'h17) return {8'h00, hi[7:0], lo[15:0]};
      return {hi[15:0], lo[15:0]};
   endfunction
   initial begin
      logic [31:0] r, lo, hi;
      logic [15:0] m;
      logic [5:0] t, u, kp;
      logic e;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      for (int a = 0; a <= 16; a += 4) begin
         apb(1'b0, 8'(a), 32'h0, r, e);
         check("reset value", r, 32'h00000000);
      end
      apb(1'b0, 8'h20, 32'h0, r, e);
      check("unmapped error", {31'h0, e}, 32'h00000001);
      apb(1'b1, SEM_OFF_EVMASK, 32'hFFFFFFFF, r, e);
      apb(1'b0, SEM_OFF_EVMASK, 32'h0, r, e);
      check("event mask bits", r, 32'h000019EB);
      kp = 6'h23 | (DEPTH >= 8 ? 6'h04 : 6'h00) | (DEPTH >= 16 ? 6'h08 : 6'h00)
         | (DEPTH >= 32 ? 6'h10 : 6'h00);
      apb(1'b1, SEM_OFF_WMMASK, 32'hFFFFFFFF, r, e);
      apb(1'b0, SEM_OFF_WMMASK, 32'h0, r, e);
      check("watermark mask bits", r, {16'h0, 2'b10, kp, 2'b10, kp});
      apb(1'b1, SEM_OFF_WMMASK, 32'h0, r, e);
      for (int k = 0; k < 16 + 40; k++) begin
         if (k < 16) m = 16'h0001 << k;
         else m = 16'($random(seed));
         if (k >= 16 || SEM_EVMASK_IMPL[k % 16]) begin
            apb(1'b1, SEM_OFF_EVMASK, {16'h0, m}, r, e);
            flagVec <= (k < 16) ? ~m : 16'($random(seed));
            repeat (3) @(posedge sys_clk);
            check("irq masked", {31'h0, irqReq},
               {31'h0, |(m & SEM_EVMASK_IMPL & flagVec)});
            flagVec <= (k < 16) ? m : ~flagVec;
            repeat (3) @(posedge sys_clk);
            check("irq event", {31'h0, irqReq},
               {31'h0, |(m & SEM_EVMASK_IMPL & flagVec)});
         end
      end
      apb(1'b1, SEM_OFF_EVMASK, 32'h0, r, e);
      for (int k = 0; k < 40; k++) begin
         t = (k == 0) ? 6'h20 : 6'($random(seed));
         u = (k == 1) ? 6'h21 : 6'($random(seed));
         apb(1'b1, SEM_OFF_WMMASK, {16'h0, 2'b10, t, 2'b10, u}, r, e);
         t = t & kp;
         u = u & kp;
         rxCnt <= (k == 0) ? 6'h3F : 6'($random(seed));
         txCnt <= ($random(seed) & 1) ? u : 6'($random(seed));
         repeat (3) @(posedge sys_clk);
         check("watermark irq", {31'h0, irqReq}, {31'h0, (t <= rxCnt && t <= DEPTH) ||
            (u == txCnt && u <= DEPTH)});
      end
      lo = $random(seed);
      hi = $random(seed);
      apb(1'b1, SEM_OFF_FILLLO, lo, r, e);
      apb(1'b1, SEM_OFF_FILLHI, hi, r, e);
      for (int wl = 1; wl < 32; wl++) begin
         wlSel <= 5'(wl);
         flagVec <= 16'($random(seed));
         fillEn <= 1'($random(seed));
         bufTxWord <= $random(seed);
         repeat (3) @(posedge sys_clk);
         check("fill word", txWord, expFill(lo & 32'h0000FFFF, hi & 32'h0000FFFF, wlSel,
            bufTxWord, flagVec[8], fillEn));
      end
      // Divisor is changed only while the peripheral is off
      apb(1'b1, SEM_OFF_BAUD, 32'h00000003, r, e);
      perEn <= 1'b1;
      repeat (40) @(posedge sys_clk);
      check("serial clock period", {16'h0, periodCnt}, 32'd8);
      results();
   end
endmodule
